// ==== common/pcu_pkg.sv ====
// Constants, register map and carrier types for the pin change unit.
package pcu_pkg;

   // ----------------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------------
   localparam int PCU_NPORT = 2;
   localparam int PCU_NPIN  = 6;
   localparam int PCU_AW    = 4;
   localparam int PCU_DW    = 8;
   localparam int PCU_NEVT  = 2;

   // ----------------------------------------------------------------------
   // Register offsets, index 0 is port A and index 1 is port C
   // ----------------------------------------------------------------------
   localparam logic [PCU_NPORT-1:0][PCU_AW-1:0] PCU_ADDR_RISE = {4'h3, 4'h0};
   localparam logic [PCU_NPORT-1:0][PCU_AW-1:0] PCU_ADDR_FALL = {4'h4, 4'h1};
   localparam logic [PCU_NPORT-1:0][PCU_AW-1:0] PCU_ADDR_FLAG = {4'h5, 4'h2};
   localparam logic [PCU_AW-1:0] PCU_ADDR_PERIPHERAL_INT_ENABLE_0       = 4'h6;
   localparam logic [PCU_AW-1:0] PCU_ADDR_PERIPHERAL_INT_REQUEST_0       = 4'h7;
   localparam logic [PCU_AW-1:0] PCU_ADDR_EVT_STATUS = 4'h8;
   localparam logic [PCU_AW-1:0] PCU_ADDR_EVT_MASK   = 4'h9;

   // ----------------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------------
   localparam int PCU_MASTER_EN_BIT = 4;
   localparam int PCU_SUMMARY_BIT   = 4;
   localparam logic [PCU_NPIN-1:0] PCU_PIN_RST  = 6'h00;
   localparam logic [PCU_NEVT-1:0] PCU_EVT_RST  = 2'h0;
   localparam logic [PCU_DW-1:0]   PCU_BYTE_RST = 8'h00;

   // ----------------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [PCU_AW-1:0] addr;
      logic [PCU_DW-1:0] wdata;
      logic              wr;
      logic              rd;
   } pcu_bus_req_t;

   typedef logic [PCU_NPORT-1:0][PCU_NPIN-1:0] pcu_pins_t;

endpackage

// ==== test/pcu_pin_source.sv ====
// Partner model of the external input pins that feed the pin change unit.
`timescale 1ns/1ps
module pcu_pin_source
(
   output pcu_pkg::pcu_pins_t pin_in
);
   import pcu_pkg::*;
   // Pins start low, so no edge is seen once reset ends.
   initial pin_in = '0;
   // Applies new pin levels at the clock edge where the bench calls it.
   task automatic drive(input pcu_pins_t v);
      pin_in <= v;
   endtask
endmodule // pcu_pin_source

// ==== test/test_pin_change_edge_interrupt.sv ====
// Self-checking bench for the pin change unit against an integer model.
`timescale 1ns/1ps
module test_pin_change_edge_interrupt;
   import pcu_pkg::*;
   logic         ref_clk = 1'b0;
   logic         reset   = 1'b1;
   pcu_bus_req_t bus     = '0;
   pcu_pins_t    pin_in;
   logic [7:0]   rd_data;
   logic         pin_change_irq;
   logic         wake_req;
   logic         event_irq;
   logic [7:0]   got;
   logic [15:0]  lfsr = 16'h9f61;
   int           mismatches = 0;
   int           checked = 0;
   int           rise_en[2], fall_en[2], flag[2], lvl[2];
   int           master = 0, evt_st = 0, evt_mask = 0;
   // ----------------------------------------------------------------------
   // Clock, design and pin source
   // ----------------------------------------------------------------------
   always #50 ref_clk = ~ref_clk;
   pcu_pin_change i_pcu_pin_change (.ref_clk(ref_clk), .reset(reset), .bus(bus), .pin_in(pin_in),
      .rd_data(rd_data), .pin_change_irq(pin_change_irq), .wake_req(wake_req), .event_irq(event_irq));
   pcu_pin_source i_pcu_pin_source (.pin_in(pin_in));
   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check_byte(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic check_bit(input string n, input logic e, input logic g);
      checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus.wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      #1 d = rd_data;
   endtask
   // Drives new pin levels and updates the model with every enabled edge.
   task automatic set_pins(input pcu_pins_t v);
      int e;
      i_pcu_pin_source.drive(v);
      for (int p = 0; p < 2; p++)
      begin
         e = (~lvl[p] & v[p] & rise_en[p]) | (lvl[p] & ~v[p] & fall_en[p]);
         flag[p] |= e;
         if (e != 0) evt_st |= 1 << p;
         lvl[p] = v[p];
      end
   endtask
   task automatic check_state();
      for (int p = 0; p < 2; p++)
      begin
         bus_rd(PCU_ADDR_FLAG[p], got);
         check_byte("flag", 8'(flag[p]), got);
      end
      bus_rd(PCU_ADDR_PERIPHERAL_INT_REQUEST_0, got);
      check_byte("summary", ((flag[0] | flag[1]) != 0) ? 8'h01 << PCU_SUMMARY_BIT : 8'h00, got);
      check_bit("irq", master != 0 && (flag[0] | flag[1]) != 0, pin_change_irq);
      check_bit("wake", master != 0 && (flag[0] | flag[1]) != 0, wake_req);
      bus_rd(PCU_ADDR_EVT_STATUS, got);
      check_byte("event status", 8'(evt_st), got);
      check_bit("event irq", (evt_st & evt_mask) != 0, event_irq);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ----------------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      for (int a = 0; a < 16; a++)
      begin
         bus_rd(4'(a), got);
         check_byte("reset value", 8'h00, got);
      end
      for (int p = 0; p < 2; p++)
      begin
         bus_wr(PCU_ADDR_RISE[p], 8'hff);
         bus_rd(PCU_ADDR_RISE[p], got);
         check_byte("rise width", 8'h3f, got);
         bus_wr(PCU_ADDR_FALL[p], 8'hff);
         bus_rd(PCU_ADDR_FALL[p], got);
         check_byte("fall width", 8'h3f, got);
         bus_wr(PCU_ADDR_RISE[p], 8'h00);
         bus_wr(PCU_ADDR_FALL[p], 8'h00);
      end
      bus_wr(PCU_ADDR_PERIPHERAL_INT_REQUEST_0, 8'hff);
      bus_rd(PCU_ADDR_PERIPHERAL_INT_REQUEST_0, got);
      check_byte("summary read-only", 8'h00, got);
      bus_wr(PCU_ADDR_PERIPHERAL_INT_ENABLE_0, 8'hff);
      bus_rd(PCU_ADDR_PERIPHERAL_INT_ENABLE_0, got);
      check_byte("master width", 8'h01 << PCU_MASTER_EN_BIT, got);
      bus_wr(PCU_ADDR_PERIPHERAL_INT_ENABLE_0, 8'h00);
      $display("test registers done");
      for (int i = 0; i < 40; i++)
      begin
         lfsr = lfsr_next(lfsr);
         rise_en[i % 2] = lfsr[5:0];
         fall_en[i % 2] = lfsr[11:6];
         master = lfsr[12];
         evt_mask = lfsr[14:13];
         bus_wr(PCU_ADDR_RISE[i % 2], 8'(rise_en[i % 2]));
         bus_wr(PCU_ADDR_FALL[i % 2], 8'(fall_en[i % 2]));
         bus_wr(PCU_ADDR_PERIPHERAL_INT_ENABLE_0, 8'(master << PCU_MASTER_EN_BIT));
         bus_wr(PCU_ADDR_EVT_MASK, 8'(evt_mask));
         lfsr = lfsr_next(lfsr);
         @(posedge ref_clk);
         set_pins(lfsr[11:0]);
         repeat (6) @(posedge ref_clk);
         check_state();
         if (lfsr[15])
         begin
            bus_rd(PCU_ADDR_FLAG[i % 2], got);
            bus_wr(PCU_ADDR_FLAG[i % 2], 8'(flag[i % 2]) & ~got);
            flag[i % 2] = 0;
            bus_wr(PCU_ADDR_EVT_STATUS, 8'h03);
            evt_st = 0;
         end
      end
      $display("test random edges done");
      @(posedge ref_clk);
      set_pins('0);
      rise_en[0] = 1;
      bus_wr(PCU_ADDR_RISE[0], 8'h01);
      bus_wr(PCU_ADDR_FLAG[0], 8'h00);
      bus_wr(PCU_ADDR_FLAG[1], 8'h00);
      flag = '{0, 0};
      @(posedge ref_clk);
      set_pins(12'h001);
      @(posedge ref_clk);
      bus_wr(PCU_ADDR_FLAG[0], 8'h00);
      repeat (3) @(posedge ref_clk);
      check_state();
      $display("test edge during clear done");
      report_and_stop();
   end
   // Cuts a hang short well beyond the expected run length.
   initial
   begin
      #(100 * 30000);
      mismatches++;
      report_and_stop();
   end
endmodule // test_pin_change_edge_interrupt

// ==== verilog/pcu_pin_change.sv ====
// Pin change edge interrupt unit with register port and event interrupt.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
// Operation
// - Request reaches CPU only with master enable.
// - Master off: flags still set, no request.
// - Each pin has rise and fall detectors.
// - Rise detector active only when enabled.
// - Fall detector active only when enabled.
// - Both enables set: either edge counts.
// - Enabled edge sets sticky per-pin flag.
// - Flag set with master on raises request.
// - Summary flag is read-only OR of flags.
// - Writing zero clears flag absent new edge.
// - Edge during flag write leaves flag set.
// - Pin change event wakes from sleep; wake_req rises only with master enable on.
// - Six pin bits, bits 7-6 read zero.
// - Enables and flags reset to zero.
module pcu_pin_change
(
   input  logic                  ref_clk,
   input  logic                  reset,
   input  pcu_pkg::pcu_bus_req_t bus,
   input  pcu_pkg::pcu_pins_t    pin_in,
   output logic [7:0]            rd_data,
   output logic                  pin_change_irq,
   output logic                  wake_req,
   output logic                  event_irq
);
   import pcu_pkg::*;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   pcu_pins_t             pin_sync1;
   pcu_pins_t             pin_sync2;
   pcu_pins_t             pin_prev;
   pcu_pins_t             rise_edge_enable_reg;
   pcu_pins_t             fall_edge_enable_reg;
   pcu_pins_t             per_pin_change_flag_reg;
   pcu_pins_t             next_flag;
   pcu_pins_t             rise_seen;
   pcu_pins_t             fall_seen;
   pcu_pins_t             hit;
   logic                  pin_change_master_enable;
   logic                  pin_change_summary_flag;
   logic [PCU_NEVT-1:0]   evt_status;
   logic [PCU_NEVT-1:0]   evt_mask;
   logic [PCU_NEVT-1:0]   port_event;
   logic [PCU_NEVT-1:0]   next_status;
   logic [PCU_NPORT-1:0]  wr_rise;
   logic [PCU_NPORT-1:0]  wr_fall;
   logic [PCU_NPORT-1:0]  wr_flag;
   logic                  wr_peripheral_int_enable_0;
   logic                  wr_status;
   logic                  wr_mask;
   logic [PCU_DW-1:0]     read_mux;

   // Enabled edges of one port: rising and falling detectors act independently.
   function automatic logic [PCU_NPIN-1:0] edge_hit(
      input logic [PCU_NPIN-1:0] r,
      input logic [PCU_NPIN-1:0] f,
      input logic [PCU_NPIN-1:0] re,
      input logic [PCU_NPIN-1:0] fe);
      edge_hit = (r & re) | (f & fe);
   endfunction

   // Read value for one address; pin registers sit in the low six bits.
   // Every source is an argument, so the continuous assignment that calls
   // this re-evaluates as soon as any register changes, not only the address.
   function automatic logic [PCU_DW-1:0] read_reg(
      input logic [PCU_AW-1:0]   a,
      input pcu_pins_t           re,
      input pcu_pins_t           fe,
      input pcu_pins_t           fl,
      input logic                me,
      input logic                sf,
      input logic [PCU_NEVT-1:0] st,
      input logic [PCU_NEVT-1:0] mk);
      logic [PCU_DW-1:0] v;
      v = PCU_BYTE_RST;
      for (int p = 0; p < PCU_NPORT; p++)
      begin
         if (a == PCU_ADDR_RISE[p]) v = {2'h0, re[p]};
         if (a == PCU_ADDR_FALL[p]) v = {2'h0, fe[p]};
         if (a == PCU_ADDR_FLAG[p]) v = {2'h0, fl[p]};
      end
      if (a == PCU_ADDR_PERIPHERAL_INT_ENABLE_0) v[PCU_MASTER_EN_BIT] = me;
      if (a == PCU_ADDR_PERIPHERAL_INT_REQUEST_0) v[PCU_SUMMARY_BIT] = sf;
      if (a == PCU_ADDR_EVT_STATUS) v[PCU_NEVT-1:0] = st;
      if (a == PCU_ADDR_EVT_MASK) v[PCU_NEVT-1:0] = mk;
      read_reg = v;
   endfunction

   // ----------------------------------------------------------------------
   // Pin synchronisers and edge sampling
   // ----------------------------------------------------------------------

   // Two-stage synchroniser followed by the previous-sample register.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         pin_sync1 <= '0;
         pin_sync2 <= '0;
         pin_prev  <= '0;
      end
      else
      begin
         pin_sync1 <= pin_in;
         pin_sync2 <= pin_sync1;
         pin_prev  <= pin_sync2;
      end
   end

   // One-cycle edge pulses from the current and previous samples.
   assign rise_seen = pin_sync2 & ~pin_prev;
   assign fall_seen = ~pin_sync2 & pin_prev;

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------

   // Global register write selects.
   assign wr_peripheral_int_enable_0   = bus.wr && (bus.addr == PCU_ADDR_PERIPHERAL_INT_ENABLE_0);
   assign wr_status = bus.wr && (bus.addr == PCU_ADDR_EVT_STATUS);
   assign wr_mask   = bus.wr && (bus.addr == PCU_ADDR_EVT_MASK);
   assign read_mux  = read_reg(bus.addr, rise_edge_enable_reg, fall_edge_enable_reg,
                               per_pin_change_flag_reg, pin_change_master_enable,
                               pin_change_summary_flag, evt_status, evt_mask);

   // ----------------------------------------------------------------------
   // Per-port enables and flags
   // ----------------------------------------------------------------------
   for (genvar p = 0; p < PCU_NPORT; p++)
   begin : g_port
      // Port write selects and detector outputs.
      assign wr_rise[p]    = bus.wr && (bus.addr == PCU_ADDR_RISE[p]);
      assign wr_fall[p]    = bus.wr && (bus.addr == PCU_ADDR_FALL[p]);
      assign wr_flag[p]    = bus.wr && (bus.addr == PCU_ADDR_FLAG[p]);
      assign hit[p]        = edge_hit(rise_seen[p], fall_seen[p],
                                      rise_edge_enable_reg[p], fall_edge_enable_reg[p]);
      assign port_event[p] = |hit[p];
      // A written value lands first and a fresh edge is ORed over it.
      assign next_flag[p]  = (wr_flag[p] ? bus.wdata[PCU_NPIN-1:0] : per_pin_change_flag_reg[p])
                             | hit[p];

      // Edge enables and sticky flags of one port.
      always_ff @(posedge ref_clk)
      begin
         if (reset)
         begin
            rise_edge_enable_reg[p]    <= PCU_PIN_RST;
            fall_edge_enable_reg[p]    <= PCU_PIN_RST;
            per_pin_change_flag_reg[p] <= PCU_PIN_RST;
         end
         else
         begin
            if (wr_rise[p]) rise_edge_enable_reg[p] <= bus.wdata[PCU_NPIN-1:0];
            if (wr_fall[p]) fall_edge_enable_reg[p] <= bus.wdata[PCU_NPIN-1:0];
            per_pin_change_flag_reg[p] <= next_flag[p];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Master enable, request, wake and event interrupt
   // ----------------------------------------------------------------------

   // Summary is the OR of every flag; it has no storage of its own.
   assign pin_change_summary_flag = |per_pin_change_flag_reg;
   // Status set wins over a write-one clear in the same cycle.
   assign next_status = (evt_status & ~(wr_status ? bus.wdata[PCU_NEVT-1:0] : PCU_EVT_RST)) | port_event;

   // Control registers and registered outputs.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         pin_change_master_enable <= 1'b0;
         evt_status               <= PCU_EVT_RST;
         evt_mask                 <= PCU_EVT_RST;
         pin_change_irq           <= 1'b0;
         wake_req                 <= 1'b0;
         event_irq                <= 1'b0;
         rd_data                  <= PCU_BYTE_RST;
      end
      else
      begin
         if (wr_peripheral_int_enable_0) pin_change_master_enable <= bus.wdata[PCU_MASTER_EN_BIT];
         if (wr_mask) evt_mask <= bus.wdata[PCU_NEVT-1:0];
         evt_status     <= next_status;
         pin_change_irq <= pin_change_master_enable & pin_change_summary_flag;
         wake_req       <= pin_change_master_enable & pin_change_summary_flag;
         event_irq      <= |(evt_status & evt_mask);
         rd_data        <= bus.rd ? read_mux : PCU_BYTE_RST;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   // The request never rises without master enable one cycle before.
   a_irq_needs_master: assert property (
      pin_change_irq |-> $past(pin_change_master_enable))
      else $error("Pin change request without master enable.");

   // With master off, enabled edges still land in the flags.
   a_detect_master_off: assert property (
      (!pin_change_master_enable && !wr_peripheral_int_enable_0 && hit != '0)
      |=> ((per_pin_change_flag_reg & $past(hit)) == $past(hit)) ##1 !pin_change_irq)
      else $error("Edge lost or request raised with master off.");

   // Detector output matches independent rise and fall enables.
   a_edge_select: assert property (
      hit == ((pin_sync2 & ~$past(pin_sync2) & rise_edge_enable_reg)
              | (~pin_sync2 & $past(pin_sync2) & fall_edge_enable_reg)))
      else $error("Edge selection differs from enables.");

   // A set flag stays set while no flag register is written.
   a_flag_sticky: assert property (
      (wr_flag == '0) |=> (($past(per_pin_change_flag_reg) & ~per_pin_change_flag_reg) == '0))
      else $error("Flag cleared without a write.");

   // A new flag with master on raises request and wake one cycle later.
   a_flag_raises_irq: assert property (
      (pin_change_master_enable && !wr_peripheral_int_enable_0 && hit != '0) |=> ##1 (pin_change_irq && wake_req))
      else $error("Flag set with master on but no request.");

   // Reading the request register shows the summary of all flags.
   a_summary_read: assert property (
      (bus.rd && bus.addr == PCU_ADDR_PERIPHERAL_INT_REQUEST_0)
      |=> (rd_data[PCU_SUMMARY_BIT] == $past(|per_pin_change_flag_reg)) && (rd_data[7:6] == 2'h0))
      else $error("Summary read wrong.");

   // Writing zero to a port flag register without edges clears it.
   a_clear_zero: assert property (
      (wr_flag[0] && bus.wdata[5:0] == 6'h00 && hit[0] == 6'h00) |=> per_pin_change_flag_reg[0] == 6'h00)
      else $error("Flag not cleared by zero write.");

   // An edge during a flag write wins over the written value.
   a_edge_wins: assert property (
      (wr_flag != '0 && hit != '0) |=> ((per_pin_change_flag_reg & $past(hit)) == $past(hit)))
      else $error("Edge lost during flag write.");

   // One rising edge gives exactly one pulse.
   a_single_pulse: assert property (
      (rise_seen != '0) |=> ((rise_seen & $past(rise_seen)) == '0))
      else $error("Edge produced more than one pulse.");

   // Event interrupt follows only an unmasked status bit.
   a_event_irq: assert property (
      event_irq |-> $past(|(evt_status & evt_mask)))
      else $error("Event interrupt without unmasked status.");

   // The checks below watch the registers from the bus side and the outputs
   // from the flag side, so a fault in the shared decode or in the detector
   // function shows up as a disagreement between the two views.

   // No flag appears without an enabled edge unless software wrote it.
   a_no_stray_flag: assert property (
      (wr_flag == '0) |=> ((per_pin_change_flag_reg & ~$past(per_pin_change_flag_reg) & ~$past(hit)) == '0))
      else $error("Flag set without an enabled edge.");

   // A rise enable write lands in the register of the addressed port.
   a_rise_write: assert property (
      (bus.wr && bus.addr == PCU_ADDR_RISE[1])
      |=> (rise_edge_enable_reg[1] == $past(bus.wdata[PCU_NPIN-1:0])))
      else $error("Rise enable write did not land.");

   // A fall enable write lands in the register of the addressed port.
   a_fall_write: assert property (
      (bus.wr && bus.addr == PCU_ADDR_FALL[0])
      |=> (fall_edge_enable_reg[0] == $past(bus.wdata[PCU_NPIN-1:0])))
      else $error("Fall enable write did not land.");

   // The master enable takes its bit from every write to its register.
   a_master_write: assert property (
      (bus.wr && bus.addr == PCU_ADDR_PERIPHERAL_INT_ENABLE_0)
      |=> (pin_change_master_enable == $past(bus.wdata[PCU_MASTER_EN_BIT])))
      else $error("Master enable write did not land.");

   // The request is the registered AND of master enable and any flag.
   a_irq_level: assert property (
      pin_change_irq == $past(pin_change_master_enable && (per_pin_change_flag_reg != '0)))
      else $error("Request level differs from master and flags.");

   // With master off no request and no wake follow in the next cycle.
   a_master_off_quiet: assert property (
      !pin_change_master_enable |=> (!pin_change_irq && !wake_req))
      else $error("Request or wake with master off.");

   // Any set flag with master on keeps the wake request up.
   a_wake_level: assert property (
      (pin_change_master_enable && per_pin_change_flag_reg != '0) |=> wake_req)
      else $error("No wake with master on and a flag set.");

   // Writing a flag register without edges stores the written value.
   a_flag_write: assert property (
      (bus.wr && bus.addr == PCU_ADDR_FLAG[1] && hit[1] == '0)
      |=> (per_pin_change_flag_reg[1] == $past(bus.wdata[PCU_NPIN-1:0])))
      else $error("Flag write did not land.");

   // Unimplemented high bits of a pin register always read zero.
   a_high_bits_zero: assert property (
      (bus.rd && bus.addr == PCU_ADDR_FLAG[1]) |=> (rd_data[7:6] == 2'h0))
      else $error("High bits of a pin register read nonzero.");

   // Read data stands for one cycle only and is zero otherwise.
   a_rd_idle_zero: assert property (
      !bus.rd |=> (rd_data == PCU_BYTE_RST))
      else $error("Read data without a read strobe.");

   // Unmapped addresses read as zero.
   a_unmapped_zero: assert property (
      (bus.rd && bus.addr > PCU_ADDR_EVT_MASK) |=> (rd_data == PCU_BYTE_RST))
      else $error("Unmapped address read nonzero.");

   // A falling edge also gives exactly one pulse.
   a_fall_pulse: assert property (
      (fall_seen != '0) |=> ((fall_seen & $past(fall_seen)) == '0))
      else $error("Falling edge produced more than one pulse.");

   // A port event beats a write-one clear of its status bit.
   a_status_set_wins: assert property (
      (wr_status && port_event != '0) |=> ((evt_status & $past(port_event)) == $past(port_event)))
      else $error("Port event lost during status clear.");

   // An unmasked status bit raises the event interrupt one cycle later.
   a_event_level: assert property (
      ((evt_status & evt_mask) != '0) |=> event_irq)
      else $error("Unmasked status without event interrupt.");

   // Every enable, flag and request is zero after a reset cycle.
   a_reset_clear: assert property (
      disable iff (1'b0) reset |=> ((rise_edge_enable_reg == '0) && (fall_edge_enable_reg == '0)
                 && (per_pin_change_flag_reg == '0) && !pin_change_master_enable && !pin_change_irq))
      else $error("Register not cleared by reset.");

   c_rise_flag: cover property (rise_seen[0][0] && rise_edge_enable_reg[0][0]);
   c_edge_in_write: cover property (wr_flag[1] && hit[1] != 6'h00);
   c_irq: cover property (!pin_change_irq ##1 pin_change_irq);
   c_masked_flag: cover property (!pin_change_master_enable && hit != '0);
   c_fall_flag: cover property (fall_seen[1] != 6'h00 && fall_edge_enable_reg[1] != 6'h00);

endmodule // pcu_pin_change
